// [bench/mcr_ctrl_asserts.sv]
// ----------------------
// Port-level properties
// ----------------------
module mcr_ctrl_asserts
    import mcr_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst_n, // Core reset
    input wire logic mdc, // Mgmt clock
    input wire logic mdio_in, // Line level
    input wire logic mdio_out, // Driven bit
    input wire logic mdio_oe, // Drive enable
    input wire logic hw_reset_low, // Reset pin
    input wire logic [1:0] clk_sel_strap, // Strap
    input wire logic [15:0] irq_events, // Events
    input wire logic irq_out_low_o, // Irq value
    input wire logic irq_out_low_oe, // Irq enable
    input wire mcr_pkg::mcr_src_t ref_src, // Source
    input wire logic ref_src_valid, // Latched
    input wire logic core_run // Running
);
    timeunit 1ns;
    timeprecision 100ps;
    // Periods with the line driven; a read owns it for the second TA bit plus 16 bits
    logic [4:0] oe_run;
    always_ff @(negedge mdc or negedge rst_n)
        if (!rst_n) oe_run <= 5'h00;
        else oe_run <= mdio_oe ? oe_run + 5'h01 : 5'h00;

    irq_sink_a: assert property (@(posedge clk) disable iff (!rst_n)
        !irq_out_low_o) else $error("irq pin driven high");
    irq_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !core_run [*3] |-> !irq_out_low_oe) else $error("irq pulled in reset");
    run_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !hw_reset_low [*3] |=> !core_run) else $error("runs in reset");
    run_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(core_run) |-> $past(hw_reset_low) && $past(hw_reset_low, 2))
        else $error("run without release");
    src_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ref_src_valid) |-> ref_src == $past(clk_sel_strap, 3))
        else $error("wrong source");
    src_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
        core_run && $past(core_run) |-> $stable(ref_src)) else $error("source moved");
    src_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
        core_run |-> ref_src_valid) else $error("source not latched");
    mdio_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(mdio_oe) || $changed(mdio_out) |-> !mdc) else $error("launch off edge");
    ta_zero_a: assert property (@(negedge mdc) disable iff (!rst_n)
        $rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*8]) else $error("bad turnaround");
    oe_span_a: assert property (@(posedge mdc) disable iff (!rst_n)
        oe_run <= 5'h11) else $error("line held too long");
endmodule : mcr_ctrl_asserts

bind mcr_ctrl mcr_ctrl_asserts chk (.clk, .rst_n, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .hw_reset_low, .clk_sel_strap, .irq_events, .irq_out_low_o, .irq_out_low_oe,
    .ref_src, .ref_src_valid, .core_run);

// [bench/mcr_sta_model.sv]
// ---------------------------
// Station management master
// ---------------------------
`include "mcr_consts.svh"

module mcr_sta_model (
    output logic mdc, // Mgmt clock
    output logic sta_drv, // Driven bit
    output logic sta_en, // Drive enable
    input wire logic mdio_line // Line level
);
    timeunit 1ns;
    timeprecision 100ps;
    int half = 40; // 12.5 MHz at most
    initial begin
        mdc = 1'b0;
        sta_drv = 1'b1;
        sta_en = 1'b0;
    end
    // Clock parks low between frames; four spare ones cover the reset wake-up
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] a,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [67:0] bits;
        bits = {36'hf_ffff_ffff, 2'b01, op, phy, a, 2'b10, wd};
        rd = 16'h0000;
        #3;
        for (int i = 67; i >= 0; i--) begin
            mdc = 1'b0;
            sta_en = !(op == `MCR_OP_READ && i < 18);
            sta_drv = bits[i];
            #(half);
            mdc = 1'b1;
            if (i < 16) rd = {rd[14:0], mdio_line};
            #(half);
        end
        mdc = 1'b0;
        sta_en = 1'b0;
    endtask : frame
endmodule : mcr_sta_model

// [bench/tb.sv]
`include "mcr_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mcr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_reset_low = 1'b0;
    logic [1:0] clk_sel_strap = 2'b11;
    logic [15:0] irq_events = 16'h0000;
    logic oe_seen = 1'b0;
    logic mdc, mdio_line, mdio_out, mdio_oe, sta_drv, sta_en;
    logic irq_out_low_o, irq_out_low_oe, ref_src_valid, core_run;
    mcr_src_t ref_src;
    logic [15:0] rd;
    int n_mismatch = 0;
    int total_checks = 0;

    always #5 clk = ~clk;
    // Pull-up wins when neither side drives
    assign mdio_line = mdio_oe ? mdio_out : (sta_en ? sta_drv : 1'b1);
    always @(posedge mdio_oe) oe_seen = 1'b1;

    mcr_ctrl dut (.clk, .rst_n, .mdc, .mdio_in(mdio_line), .mdio_out, .mdio_oe,
        .hw_reset_low, .clk_sel_strap, .irq_events, .irq_out_low_o, .irq_out_low_oe,
        .ref_src, .ref_src_valid, .core_run);
    mcr_sta_model sta (.mdc, .sta_drv, .sta_en, .mdio_line);

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [4:0] phy, input logic [4:0] a, input logic [15:0] d);
        sta.frame(`MCR_OP_WRITE, phy, a, d, rd);
    endtask : wr

    task automatic rd_reg(input logic [4:0] phy, input logic [4:0] a);
        sta.frame(`MCR_OP_READ, phy, a, 16'h0000, rd);
    endtask : rd_reg

    task automatic boot(input logic [1:0] s);
        hw_reset_low <= 1'b0;
        clk_sel_strap <= s;
        repeat (50) @(posedge clk);
        check(16'(core_run), 16'h0000);
        hw_reset_low <= 1'b1;
        repeat (6) @(posedge clk);
        check(16'(core_run), 16'h0001);
        check(16'(ref_src_valid), 16'h0001);
        check(16'(ref_src), 16'(s));
        clk_sel_strap <= ~s;
        repeat (8) @(posedge clk);
        check(16'(ref_src), 16'(s));
    endtask : boot

    task automatic pulse(input logic [15:0] e);
        @(posedge clk);
        irq_events <= e;
        @(posedge clk);
        irq_events <= 16'h0000;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic mgmt_test();
        wr(5'h00, 5'h05, 16'ha5c3);
        wr(5'h00, 5'h1f, 16'h8001);
        #2000;
        rd_reg(5'h00, 5'h05);
        check(rd, 16'ha5c3);
        sta.half = 150;
        rd_reg(5'h00, 5'h1f);
        check(rd, 16'h8001);
        sta.half = 40;
        oe_seen = 1'b0;
        wr(5'h03, 5'h05, 16'h0000);
        rd_reg(5'h03, 5'h05);
        check(rd, 16'hffff);
        check(16'(oe_seen), 16'h0000);
        // An undefined op must leave the register alone
        sta.frame(2'b11, 5'h00, 5'h05, 16'h0000, rd);
        rd_reg(5'h00, 5'h05);
        check(rd, 16'ha5c3);
    endtask : mgmt_test

    task automatic irq_test();
        wr(5'h00, 5'h00, 16'h0004);
        pulse(16'h0008);
        check(16'(irq_out_low_oe), 16'h0000);
        pulse(16'h0004);
        check(16'(irq_out_low_oe), 16'h0001);
        check(16'(irq_out_low_o), 16'h0000);
        rd_reg(5'h00, 5'h01);
        check(rd, 16'h000c);
        pulse(16'h0000);
        check(16'(irq_out_low_oe), 16'h0000);
        pulse(16'h0004);
        hw_reset_low <= 1'b0;
        repeat (6) @(posedge clk);
        check(16'(core_run), 16'h0000);
        check(16'(irq_out_low_oe), 16'h0000);
        boot(2'b10);
    endtask : irq_test

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int s = 0; s < 4; s++) boot(2'(s));
        mgmt_test();
        irq_test();
        stop_test();
    end

    // Frames take about 5.4 us, about 20 us at the slow rate; the limit leaves ample slack
    initial begin
        #300000;
        n_mismatch++;
        stop_test();
    end
endmodule : tb

// [logic/mcr_ctrl.sv]
`include "mcr_consts.svh"

// Notes on behaviour
// R1: The management port works with a management clock of up to 12.5 MHz, and the controller never goes faster.
// R2: The management logic keeps its state whenever the management clock stops, since it only moves on that clock's edges.
// R3: Data on the shared line is launched and captured on management clock edges in both directions.
// R4: The interrupt pin is open drain: it is pulled low while an interrupt is pending and released otherwise.
// R5: The two-bit strap picks the reference: 00 diff 156.25 MHz, 01 diff 125 MHz, 10 diff 25 MHz, 11 crystal 25 MHz.
// R6: Board logic holds reset low until the crystal has run at least 10 cycles before releasing it.
// R7: A low on the hardware reset input holds the device in reset for as long as it lasts; high is normal operation.
// R8: The strap is sampled when reset is released and the chosen source then stays fixed until the next reset.
module mcr_ctrl
    import mcr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = `MCR_PHY_ADDR_DEFAULT
) (
    input wire logic clk, // Core clock, 100 MHz
    input wire logic rst_n, // Core async reset, active low
    input wire logic mdc, // Management clock from the controller
    input wire logic mdio_in, // Management data pin level
    output logic mdio_out, // Management data driven value
    output logic mdio_oe, // High while the device drives data
    input wire logic hw_reset_low, // Hardware reset pin, active low
    input wire logic [1:0] clk_sel_strap, // Reference source strap
    input wire logic [15:0] irq_events, // Event pulses from the core
    output logic irq_out_low_o, // Interrupt pin value, always low
    output logic irq_out_low_oe, // Interrupt pin enable, high pulls low
    output mcr_pkg::mcr_src_t ref_src, // Chosen reference clock source
    output logic ref_src_valid, // Source latched since reset release
    output logic core_run // High while device is out of reset
);
    import mcr_pkg::*;

    // ------------------------------------------------------------
    // Hardware reset pin and strap
    // ------------------------------------------------------------
    logic rst_pin_sync;
    logic rst_pin_q;
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;

    mcr_sync2 u_rst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(hw_reset_low),
        .q(rst_pin_sync)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= 2'h0;
            strap_sync <= 2'h0;
        end else begin
            strap_meta <= clk_sel_strap;
            strap_sync <= strap_meta;
        end
    end

    // Low level holds the device in reset for as long as it lasts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pin_q <= 1'b0;
            core_run <= 1'b0;
        end else begin
            rst_pin_q <= rst_pin_sync;
            core_run <= rst_pin_sync; // [R7]
        end
    end

    // Strap caught on the release edge, then frozen; the board is trusted
    // to have held reset until the crystal was stable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_src <= MCR_SRC_XTAL_25;
            ref_src_valid <= 1'b0;
        end else if (!rst_pin_sync) begin
            ref_src_valid <= 1'b0; // [R7]
        end else if (!rst_pin_q) begin
            ref_src <= mcr_decode_src(strap_sync); // [R5] [R8]
            ref_src_valid <= 1'b1; // [R8]
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, core domain
    // ------------------------------------------------------------
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic clr_tgl_meta;
    logic clr_tgl_sync;
    logic clr_tgl_q;
    logic clr_req_tgl;
    logic [15:0] mask_shadow;
    logic mask_tgl;
    logic mask_tgl_meta;
    logic mask_tgl_sync;
    logic mask_tgl_q;
    logic clr_pulse;
    logic mask_pulse;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_tgl_meta <= 1'b0;
            clr_tgl_sync <= 1'b0;
            clr_tgl_q <= 1'b0;
            mask_tgl_meta <= 1'b0;
            mask_tgl_sync <= 1'b0;
            mask_tgl_q <= 1'b0;
        end else begin
            clr_tgl_meta <= clr_req_tgl;
            clr_tgl_sync <= clr_tgl_meta;
            clr_tgl_q <= clr_tgl_sync;
            mask_tgl_meta <= mask_tgl;
            mask_tgl_sync <= mask_tgl_meta;
            mask_tgl_q <= mask_tgl_sync;
        end
    end

    assign clr_pulse = clr_tgl_sync ^ clr_tgl_q;
    assign mask_pulse = mask_tgl_sync ^ mask_tgl_q;

    // New events win over a read-clear landing in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 16'h0000;
        end else if (!core_run) begin
            irq_status <= 16'h0000;
        end else if (clr_pulse) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // Shadow is stable for two core cycles before the toggle arrives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= 16'h0000;
        end else if (!core_run) begin
            irq_mask <= 16'h0000;
        end else if (mask_pulse) begin
            irq_mask <= mask_shadow;
        end
    end

    // Only ever sinks: value held low, enable asserts the pull-down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_low_o <= 1'b0;
            irq_out_low_oe <= 1'b0;
        end else begin
            irq_out_low_o <= 1'b0; // [R4]
            irq_out_low_oe <= |(irq_status & irq_mask); // [R4]
        end
    end

    // ------------------------------------------------------------
    // Management port, management clock domain
    // ------------------------------------------------------------
    // Everything below except status_cap moves only on mdc edges, so a stopped clock just
    // freezes the frame where it is; no timeout is kept on the core side
    logic mdc_rst_meta;
    logic mdc_rst_n;
    mcr_state_t state;
    logic [5:0] bit_cnt;
    logic [13:0] cmd_sr;
    logic [15:0] data_sr;
    logic is_read;
    logic is_write;
    logic addr_hit;
    logic [4:0] reg_addr;
    logic [15:0] regs [`MCR_REG_COUNT];
    logic [15:0] status_cap;
    logic [15:0] stat_snap;

    // Port held in reset with the core: asserts at once, releases on mdc,
    // so a frame cut by a hardware reset can never leave stale toggles behind
    always_ff @(posedge mdc or negedge core_run) begin
        if (!core_run) begin
            mdc_rst_meta <= 1'b0;
            mdc_rst_n <= 1'b0; // [R7]
        end else begin
            mdc_rst_meta <= 1'b1;
            mdc_rst_n <= mdc_rst_meta;
        end
    end

    // Status frozen in the core domain when the read-clear toggle lands; the
    // mdc side samples it one mdc period later, long after it has settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_cap <= 16'h0000;
        end else if (clr_pulse) begin
            status_cap <= irq_status; // [R1]
        end
    end

    always_ff @(posedge mdc or negedge mdc_rst_n) begin
        if (!mdc_rst_n) begin
            state <= MCR_ST_PRE;
            bit_cnt <= 6'd0;
            cmd_sr <= 14'h0000;
            is_read <= 1'b0;
        end else begin
            unique case (state)
                MCR_ST_PRE: begin
                    if (mdio_in) begin
                        if (bit_cnt < `MCR_PREAMBLE_BITS) begin
                            bit_cnt <= bit_cnt + 6'd1;
                        end
                    end else if (bit_cnt == `MCR_PREAMBLE_BITS) begin
                        state <= MCR_ST_CMD; // [R3]
                        bit_cnt <= 6'd1;
                        cmd_sr <= 14'h0000;
                    end else begin
                        bit_cnt <= 6'd0;
                    end
                end
                MCR_ST_CMD: begin
                    cmd_sr <= {cmd_sr[12:0], mdio_in}; // [R3]
                    bit_cnt <= bit_cnt + 6'd1;
                    if (bit_cnt == 6'd13) begin
                        state <= MCR_ST_TA;
                        bit_cnt <= 6'd0;
                        // Op sits one place short of its final slot here
                        is_read <= (cmd_sr[10:9] == `MCR_OP_READ);
                    end
                end
                MCR_ST_TA: begin
                    bit_cnt <= bit_cnt + 6'd1;
                    if (bit_cnt == 6'd1) begin
                        state <= MCR_ST_DATA;
                        bit_cnt <= 6'd0;
                    end
                end
                MCR_ST_DATA: begin
                    bit_cnt <= bit_cnt + 6'd1;
                    if (bit_cnt == 6'd15) begin
                        state <= MCR_ST_PRE;
                        bit_cnt <= 6'd0;
                    end
                end
                default: begin
                    state <= MCR_ST_PRE;
                    bit_cnt <= 6'd0;
                end
            endcase
        end
    end

    // Fields: start[13:12] op[11:10] phy[9:5] reg[4:0]
    assign addr_hit = (cmd_sr[13:12] == `MCR_START_CODE) && (cmd_sr[9:5] == PHY_ADDR);
    assign reg_addr = cmd_sr[4:0];
    assign is_write = (cmd_sr[11:10] == `MCR_OP_WRITE);

    // Write data shifted in on rising mdc; written at the last bit
    always_ff @(posedge mdc or negedge mdc_rst_n) begin
        if (!mdc_rst_n) begin
            data_sr <= 16'h0000;
            mask_shadow <= 16'h0000;
            mask_tgl <= 1'b0;
            clr_req_tgl <= 1'b0;
            stat_snap <= 16'h0000;
        end else if (state == MCR_ST_TA && bit_cnt == 6'd0) begin
            // Ask the core for a frozen copy one mdc period before it is used
            if (is_read && addr_hit && reg_addr == 5'd1) begin
                clr_req_tgl <= ~clr_req_tgl;
            end
        end else if (state == MCR_ST_TA && bit_cnt == 6'd1) begin
            stat_snap <= status_cap;
        end else if (state == MCR_ST_DATA) begin
            data_sr <= {data_sr[14:0], mdio_in}; // [R3]
            if (bit_cnt == 6'd15 && is_write && addr_hit && reg_addr == 5'd0) begin
                mask_shadow <= {data_sr[14:0], mdio_in};
                mask_tgl <= ~mask_tgl;
            end
        end
    end

    always_ff @(posedge mdc or negedge mdc_rst_n) begin
        if (!mdc_rst_n) begin
            for (int i = 0; i < `MCR_REG_COUNT; i++) begin
                regs[i] <= 16'h0000;
            end
        end else if (state == MCR_ST_DATA && bit_cnt == 6'd15 && is_write && addr_hit) begin
            regs[reg_addr] <= {data_sr[14:0], mdio_in};
        end
    end

    // Read data launched on falling mdc so it is settled for the
    // controller's rising-edge capture, with a full half period margin
    logic [15:0] rd_word;
    assign rd_word = (reg_addr == 5'd1) ? stat_snap : regs[reg_addr];

    always_ff @(negedge mdc or negedge mdc_rst_n) begin
        if (!mdc_rst_n) begin
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (is_read && addr_hit && state == MCR_ST_TA && bit_cnt == 6'd1) begin
            mdio_out <= 1'b0; // [R3]
            mdio_oe <= 1'b1;
        end else if (is_read && addr_hit && state == MCR_ST_DATA) begin
            mdio_out <= rd_word[4'd15 - bit_cnt[3:0]]; // [R3] [R1]
            mdio_oe <= 1'b1;
        end else begin
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0; // [R2]
        end
    end
endmodule : mcr_ctrl

// [logic/mcr_sync2.sv]
module mcr_sync2 (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Async reset, active low
    input wire logic d, // Level from another domain
    output logic q // Synchronised level
);
    logic meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : mcr_sync2

// [pkg/mcr_consts.svh]
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// Management clock ceiling, in kHz, and the core clock rate
`define MCR_MDC_MAX_KHZ 12500
`define MCR_CLK_KHZ 100000
// Frame layout
`define MCR_PREAMBLE_BITS 6'd32
`define MCR_START_CODE 2'b01
`define MCR_OP_WRITE 2'b01
`define MCR_OP_READ 2'b10
`define MCR_TA_WRITE 2'b10
`define MCR_FRAME_BITS 6'd32
// Strap encodings
`define MCR_SEL_DIFF_156 2'b00
`define MCR_SEL_DIFF_125 2'b01
`define MCR_SEL_DIFF_25 2'b10
`define MCR_SEL_XTAL_25 2'b11
// Shortest reset hold that the board must give, in crystal cycles
`define MCR_XTAL_MIN_CYCLES 4'd10
// Depth of the register array behind the management port
`define MCR_REG_COUNT 32
`define MCR_PHY_ADDR_DEFAULT 5'h00

`endif

// [pkg/mcr_pkg.sv]
`include "mcr_consts.svh"

package mcr_pkg;
    typedef enum logic [1:0] {
        MCR_SRC_DIFF_156,
        MCR_SRC_DIFF_125,
        MCR_SRC_DIFF_25,
        MCR_SRC_XTAL_25
    } mcr_src_t;

    typedef enum logic [2:0] {
        MCR_ST_PRE,
        MCR_ST_CMD,
        MCR_ST_TA,
        MCR_ST_DATA,
        MCR_ST_IDLE
    } mcr_state_t;

    function automatic mcr_src_t mcr_decode_src(input logic [1:0] strap);
        unique case (strap)
            `MCR_SEL_DIFF_156: mcr_decode_src = MCR_SRC_DIFF_156;
            `MCR_SEL_DIFF_125: mcr_decode_src = MCR_SRC_DIFF_125;
            `MCR_SEL_DIFF_25: mcr_decode_src = MCR_SRC_DIFF_25;
            default: mcr_decode_src = MCR_SRC_XTAL_25;
        endcase
    endfunction : mcr_decode_src
endpackage : mcr_pkg
